// ===== hw/misc_pkg.sv
/*
 * Constants shared by the miscellaneous control register bank and its
 * self-test sequencer: byte addresses, field positions, reset values and
 * self-test timing. Assumes a 125 MHz system clock.
 */
// Summary of operation
// R1 - Sixteen-bit control register, readable and writable
// R2 - Register reads 0x0000 until first write
// R3 - Data-ready settings survive any device reset
// R4 - Self-test enable bit 8 cleared on reset
// R5 - Bit 10 suppresses self-test at power-up/reset
// R6 - Bit 9 drives the single reverse-rotation output
// R7 - Bit 8 runs continuous self-test
// R8 - Bits 2..0: enable, polarity, pin select
// R9 - Pin active on cycle end, inactive mid-conversion
// R10 - Pin priority: misc, then alarm, then general
// R11 - Self-test pass/fail shown in status bit 5
// R12 - Self-test speeds sample period, then restores it
// R13 - Unused bits read zero, writes ignored
`default_nettype none
package misc_pkg;
   // Register location, low and high byte
   localparam logic [6:0]  MISC_ADDR_LO     = 7'h34;
   localparam logic [6:0]  MISC_ADDR_HI     = 7'h35;
   localparam logic [15:0] MISC_RESET       = 16'h0000;
   // Field positions within the 16-bit word
   localparam int          NO_BOOT_TEST_BIT = 10;
   localparam int          REVERSE_BIT      = 9;
   localparam int          TEST_ENABLE_BIT  = 8;
   localparam int          RDY_ENABLE_BIT   = 2;
   localparam int          RDY_POL_BIT      = 1;
   localparam int          RDY_SEL_BIT      = 0;
   // Self-test timing
   localparam int          CLK_KHZ          = 125000;
   localparam int          TEST_HP_MS       = 13;
   localparam int          TEST_LP_MS       = 35;
   localparam int          TEST_HP_CYCLES   = TEST_HP_MS * CLK_KHZ;
   localparam int          TEST_LP_CYCLES   = TEST_LP_MS * CLK_KHZ;
   localparam int          TEST_CNT_W       = 23;
   // Sample period while self-test runs
   localparam logic [7:0]  TEST_FAST_PERIOD = 8'h01;
endpackage
`default_nettype wire

// ===== hw/st_if.sv
/*
 * Handshake between the register bank and the self-test sequencer.
 * Assumes both ends share mclk_i.
 */
`timescale 1ns/1ns
`default_nettype none
interface test_if #(parameter int CW = 23);
   logic          start;
   logic [CW-1:0] limit;
   logic          busy;
   logic          done;
   modport ctrl (output start, output limit, input busy, input done);
   modport seq  (input start, input limit, output busy, output done);
endinterface
`default_nettype wire

// ===== hw/self_test_seq.sv
/*
 * Self-test run timer: runs for limit cycles after a start pulse, then
 * pulses done. Assumes start is ignored while a run is in progress.
 */
`timescale 1ns/1ns
`default_nettype none
module self_test_seq #(
   parameter int CW = 23
) (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic resetn_i,
   // Control handshake
   test_if.seq       tst
);
   typedef enum logic {RUN_IDLE, RUN_BUSY} run_state_t;

   run_state_t    state;
   run_state_t    next_state;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic [CW-1:0] lim;
   logic [CW-1:0] next_lim;
   logic          busy;
   logic          next_busy;
   logic          done;
   logic          next_done;

   // Run timer; a start during a run is dropped. Length is latched at
   // start, so a mode change mid-run cannot push the count past its end.
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_lim   = lim;
      next_busy  = busy;
      next_done  = 1'b0;
      case (state)
         RUN_IDLE: begin
            if (tst.start) begin
               next_state = RUN_BUSY;
               next_cnt   = '0;
               next_lim   = tst.limit;
               next_busy  = 1'b1;
            end
         end
         RUN_BUSY: begin
            if (cnt == lim - CW'(1)) begin // R5
               next_state = RUN_IDLE;
               next_busy  = 1'b0;
               next_done  = 1'b1;
            end else begin
               next_cnt = cnt + CW'(1);
            end
         end
         default: next_state = RUN_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= RUN_IDLE;
         cnt   <= '0;
         lim   <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         lim   <= next_lim;
         busy  <= next_busy;
         done  <= next_done;
      end
   end

   assign tst.busy = busy;
   assign tst.done = done;

   chk_run_length: assert property (@(posedge mclk_i) disable iff (!resetn_i) // R5
      $rose(done) |-> $past(cnt) == $past(lim) - CW'(1))
      else $error("self-test ended at wrong count");
endmodule
`default_nettype wire

// ===== hw/misc_control_bank.sv
/*
 * Miscellaneous control register with data-ready pin drive, pin priority
 * against alarm and general-purpose controls, and self-test control.
 * Assumes a register port with byte writes and word reads, synchronous to mclk_i, and that
 * porn_i clears the retained (flash-backed) fields only at first power.
 */
`timescale 1ns/1ns
`default_nettype none
module misc_control_bank #(
   parameter int TEST_HP_CYCLES = misc_pkg::TEST_HP_CYCLES,
   parameter int TEST_LP_CYCLES = misc_pkg::TEST_LP_CYCLES
) (
   // Clock and resets
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   input  wire logic       porn_i,
   // Register port
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [6:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic     [15:0] reg_rdata_o,
   // Sensor processing events and status
   input  wire logic       low_power_i,
   input  wire logic       cycle_done_i,
   input  wire logic       conv_mid_i,
   input  wire logic       test_pass_i,
   input  wire logic [7:0] smpl_period_i,
   // Lower-priority claims on the auxiliary pins
   input  wire logic [1:0] alarm_claim_i,
   input  wire logic [1:0] alarm_level_i,
   input  wire logic [1:0] gpio_out_en_i,
   input  wire logic [1:0] gpio_level_i,
   // Auxiliary pins and derived controls
   output logic     [1:0]  aux_pin_o,
   output logic     [1:0]  aux_pin_oe_o,
   output logic            reverse_rotation_o,
   output logic            self_test_active_o,
   output logic            test_fail_status_o,
   output logic     [7:0]  smpl_period_o
);
   localparam int CW = misc_pkg::TEST_CNT_W;

   // Retained fields
   logic no_boot_test, next_no_boot_test;
   logic reverse,      next_reverse;
   logic rdy_en,       next_rdy_en;
   logic rdy_pol,      next_rdy_pol;
   logic rdy_sel,      next_rdy_sel;
   // Volatile state
   logic        test_enable,  next_test_enable;
   logic        boot_pending, next_boot_pending;
   logic        rdy_active,   next_rdy_active;
   logic        test_fail,    next_test_fail;
   logic [15:0] rdata,        next_rdata;
   logic [1:0]  pin,          next_pin;
   logic [1:0]  pin_oe,       next_pin_oe;
   logic        rev_q,        next_rev_q;
   logic [7:0]  period,       next_period;
   logic [15:0] word;
   logic        wr_lo;
   logic        wr_hi;

   test_if #(.CW(CW)) tst ();

   self_test_seq #(.CW(CW)) u_seq (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .tst      (tst)
   );

   assign wr_lo = reg_wr_i && (reg_addr_i == misc_pkg::MISC_ADDR_LO);
   assign wr_hi = reg_wr_i && (reg_addr_i == misc_pkg::MISC_ADDR_HI);

   // Assembled word; unused bits are constant zero
   always_comb begin
      word                                = misc_pkg::MISC_RESET; // R2 R13
      word[misc_pkg::NO_BOOT_TEST_BIT]    = no_boot_test;
      word[misc_pkg::REVERSE_BIT]         = reverse;
      word[misc_pkg::TEST_ENABLE_BIT]     = test_enable;
      word[misc_pkg::RDY_ENABLE_BIT]      = rdy_en;
      word[misc_pkg::RDY_POL_BIT]         = rdy_pol;
      word[misc_pkg::RDY_SEL_BIT]         = rdy_sel;
   end

   // Register writes; only defined bits of each byte are stored
   always_comb begin
      next_no_boot_test = no_boot_test;
      next_reverse      = reverse;
      next_test_enable  = test_enable;
      next_rdy_en       = rdy_en;
      next_rdy_pol      = rdy_pol;
      next_rdy_sel      = rdy_sel;
      if (wr_hi) begin // R1 R13
         next_no_boot_test = reg_wdata_i[misc_pkg::NO_BOOT_TEST_BIT - 8];
         next_reverse      = reg_wdata_i[misc_pkg::REVERSE_BIT - 8];
         next_test_enable  = reg_wdata_i[misc_pkg::TEST_ENABLE_BIT - 8];
      end
      if (wr_lo) begin // R8
         next_rdy_en  = reg_wdata_i[misc_pkg::RDY_ENABLE_BIT];
         next_rdy_pol = reg_wdata_i[misc_pkg::RDY_POL_BIT];
         next_rdy_sel = reg_wdata_i[misc_pkg::RDY_SEL_BIT];
      end
   end

   // Flash-backed fields ignore device reset, only first power clears them
   always_ff @(posedge mclk_i or negedge porn_i) begin
      if (!porn_i) begin // R3
         no_boot_test <= 1'b0;
         reverse      <= 1'b0;
         rdy_en       <= 1'b0;
         rdy_pol      <= 1'b0;
         rdy_sel      <= 1'b0;
      end else begin
         no_boot_test <= next_no_boot_test;
         reverse      <= next_reverse;
         rdy_en       <= next_rdy_en;
         rdy_pol      <= next_rdy_pol;
         rdy_sel      <= next_rdy_sel;
      end
   end

   // Self-test control: boot run unless suppressed, then continuous runs while bit 8 is set
   always_comb begin
      next_boot_pending = 1'b0;
      tst.start         = (boot_pending && !no_boot_test) // R5
                          || (test_enable && !tst.busy); // R7
      tst.limit         = low_power_i ? CW'(TEST_LP_CYCLES) : CW'(TEST_HP_CYCLES);
      next_test_fail    = tst.done ? !test_pass_i : test_fail; // R11
      next_period       = tst.busy ? misc_pkg::TEST_FAST_PERIOD : smpl_period_i; // R12
      next_rev_q        = reverse; // R6
   end

   // Data-ready level: completion wins over a same-cycle mid-conversion
   always_comb begin
      next_rdy_active = rdy_active;
      if (cycle_done_i) begin // R9
         next_rdy_active = 1'b1;
      end else if (conv_mid_i) begin
         next_rdy_active = 1'b0;
      end
   end

   // Pin arbitration per pin
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (rdy_en && (rdy_sel == i[0])) begin // R10 R8
            next_pin[i]    = rdy_active ? rdy_pol : !rdy_pol;
            next_pin_oe[i] = 1'b1;
         end else if (alarm_claim_i[i]) begin
            next_pin[i]    = alarm_level_i[i];
            next_pin_oe[i] = 1'b1;
         end else if (gpio_out_en_i[i]) begin
            next_pin[i]    = gpio_level_i[i];
            next_pin_oe[i] = 1'b1;
         end else begin
            next_pin[i]    = 1'b0;
            next_pin_oe[i] = 1'b0;
         end
      end
   end

   // Read answer, held until the next read
   always_comb begin
      next_rdata = rdata;
      if (reg_rd_i) begin
         next_rdata = ((reg_addr_i == misc_pkg::MISC_ADDR_LO) ||
                       (reg_addr_i == misc_pkg::MISC_ADDR_HI)) ? word : 16'h0000; // R1
      end
   end

   // Device-reset state; self-test enable is volatile
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         test_enable  <= 1'b0; // R4
         boot_pending <= 1'b1;
         rdy_active   <= 1'b0;
         test_fail    <= 1'b0;
         rdata        <= misc_pkg::MISC_RESET;
         pin          <= 2'h0;
         pin_oe       <= 2'h0;
         rev_q        <= 1'b0;
         period       <= 8'h00;
      end else begin
         test_enable  <= next_test_enable;
         boot_pending <= next_boot_pending;
         rdy_active   <= next_rdy_active;
         test_fail    <= next_test_fail;
         rdata        <= next_rdata;
         pin          <= next_pin;
         pin_oe       <= next_pin_oe;
         rev_q        <= next_rev_q;
         period       <= next_period;
      end
   end

   // Outputs straight from flops
   assign reg_rdata_o        = rdata;
   assign aux_pin_o          = pin;
   assign aux_pin_oe_o       = pin_oe;
   assign reverse_rotation_o = rev_q;
   assign self_test_active_o = tst.busy;
   assign test_fail_status_o = test_fail;
   assign smpl_period_o      = period;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   sequence rdy_event_on_pin0;
      cycle_done_i && rdy_en && !rdy_sel && rdy_pol;
   endsequence
   sequence rdy_config_holds;
      !conv_mid_i && rdy_en && !rdy_sel && rdy_pol;
   endsequence

   chk_read_word: assert property ( // R1
      (reg_rd_i && reg_addr_i == misc_pkg::MISC_ADDR_LO) |=> reg_rdata_o == $past(word))
      else $error("read answer differs from register");
   chk_unused_zero: assert property ( // R13
      reg_rdata_o[15:11] == 5'h00 && reg_rdata_o[7:3] == 5'h00)
      else $error("unused bits read nonzero");
   chk_rdy_write: assert property ( // R8
      wr_lo |=> rdy_en == $past(reg_wdata_i[2]) && rdy_sel == $past(reg_wdata_i[0]))
      else $error("data-ready fields not written");
   chk_test_cleared: assert property ( // R4
      $rose(resetn_i) |-> !test_enable)
      else $error("self-test enable survived reset");
   chk_boot_test: assert property ( // R5
      ($rose(resetn_i) && !no_boot_test) |=> tst.busy)
      else $error("boot self-test did not start");
   chk_cont_test: assert property ( // R7
      (test_enable && !tst.busy && !wr_hi) |=> tst.busy)
      else $error("continuous self-test did not restart");
   chk_rdy_pulse: assert property ( // R9
      rdy_event_on_pin0 ##1 rdy_config_holds |=> aux_pin_o[0] && aux_pin_oe_o[0])
      else $error("data-ready pin not active after cycle end");
   chk_alarm_prio: assert property ( // R10
      (!(rdy_en && rdy_sel) && alarm_claim_i[1]) |=> aux_pin_o[1] == $past(alarm_level_i[1]))
      else $error("alarm claim lost on pin one");
   chk_reverse_out: assert property ( // R6
      wr_hi |=> ##1 reverse_rotation_o == $past(reg_wdata_i[1], 2))
      else $error("reverse rotation not applied");
   chk_period_restore: assert property ( // R12
      $fell(tst.busy) |=> smpl_period_o == $past(smpl_period_i))
      else $error("sample period not restored");
   chk_fail_status: assert property ( // R11
      tst.done |=> test_fail_status_o == !$past(test_pass_i))
      else $error("self-test result not reported");
endmodule
`default_nettype wire

// ===== tb/host_model.sv
/*
 * Host side of the register port: byte writes and word reads.
 * Assumes the bank takes a strobe on the rising edge and registers a read
 * answer on that same edge.
 */
`timescale 1ns/1ns
`default_nettype none
module host_model (
   // Clock
   input  wire logic        mclk_i,
   // Register port toward the bank
   output logic             reg_wr_o,
   output logic             reg_rd_o,
   output logic [6:0]       reg_addr_o,
   output logic [7:0]       reg_wdata_o,
   input  wire logic [15:0] reg_rdata_i
);
   // Idle port at time zero
   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = 7'h00;
      reg_wdata_o = 8'h00;
   end

   // Byte write; released lines show junk, never the old value
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_wr_o    <= 1'b1;
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      @(posedge mclk_i);
      reg_wr_o    <= 1'b0;
      reg_addr_o  <= ~a;
      reg_wdata_o <= ~d;
   endtask

   // Word read, answer taken mid-cycle once it has landed
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      reg_rd_o   <= 1'b1;
      reg_addr_o <= a;
      @(posedge mclk_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~a;
      @(negedge mclk_i);
      d = reg_rdata_i;
   endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
/*
 * Self-checking bench for the miscellaneous control bank.
 * Assumes shortened self-test lengths; a reference word is kept here.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int HP = 20;
   localparam int LP = 50;
   // Stimulus, observations and reference state
   logic        mclk, resetn, porn, wr, rd, low_power, cyc_done, conv_mid, test_pass;
   logic        rev, test_act, test_fail;
   logic [6:0]  addr;
   logic [7:0]  wdata, period, period_o;
   logic [15:0] rdata, model_reg, got;
   logic [1:0]  alm_claim, alm_lvl, gp_en, gp_lvl, pin, oe;
   logic [31:0] seed;
   int          n_mismatch, num_checks;

   misc_control_bank #(.TEST_HP_CYCLES(HP), .TEST_LP_CYCLES(LP)) i_misc_control_bank (
      .mclk_i(mclk), .resetn_i(resetn), .porn_i(porn), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .low_power_i(low_power),
      .cycle_done_i(cyc_done), .conv_mid_i(conv_mid), .test_pass_i(test_pass),
      .smpl_period_i(period), .alarm_claim_i(alm_claim), .alarm_level_i(alm_lvl),
      .gpio_out_en_i(gp_en), .gpio_level_i(gp_lvl), .aux_pin_o(pin), .aux_pin_oe_o(oe),
      .reverse_rotation_o(rev), .self_test_active_o(test_act), .test_fail_status_o(test_fail),
      .smpl_period_o(period_o));

   host_model i_host_model (
      .mclk_i(mclk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata));

   // Free-running 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic final_report();
      if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // Write a byte and track it; unused bits never stick
   task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
      i_host_model.wr(a, d);
      if (a == 7'h34) model_reg[7:0] = d & 8'h07;
      else if (a == 7'h35) model_reg[15:8] = d & 8'h07;
   endtask

   // Other addresses answer zero
   task automatic rd_chk(input logic [6:0] a);
      i_host_model.rd(a, got);
      check(got, (a == 7'h34 || a == 7'h35) ? model_reg : 16'h0000);
   endtask

   // Bounded wait; running out ends the run
   task automatic wait_test(input logic lvl);
      int n;
      n = 0;
      while (test_act !== lvl && n < 300) begin
         n++;
         @(negedge mclk);
      end
      if (test_act !== lvl) begin
         n_mismatch++;
         final_report();
      end
   endtask

   // Measures one self-test run, then its outcome and period restore
   task automatic run_len(input int exp);
      int n;
      n = 0;
      while (test_act === 1'b1 && n < 300) begin
         n++;
         if (n == 4) check(16'(period_o), 16'h0001);
         @(negedge mclk);
      end
      check(16'(n), 16'(exp));
      // A run that never ends has already been counted above
      if (test_act === 1'b1) final_report();
      @(negedge mclk);
      check(16'(test_fail), 16'(!test_pass));
      check(16'(period_o), 16'(period));
   endtask

   // Device reset; first-power clear only when p is set
   task automatic do_reset(input logic p);
      @(posedge mclk);
      resetn <= 1'b0;
      porn   <= !p;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      porn   <= 1'b1;
      if (p) model_reg = 16'h0000;
      else model_reg[8] = 1'b0;
      repeat (2) @(negedge mclk);
   endtask

   task automatic pulse(input logic done);
      @(posedge mclk);
      if (done) cyc_done <= 1'b1;
      else conv_mid <= 1'b1;
      @(posedge mclk);
      cyc_done <= 1'b0;
      conv_mid <= 1'b0;
      repeat (3) @(negedge mclk);
   endtask

   // Main sequence
   initial begin
      {resetn, porn, low_power, cyc_done, conv_mid} = 5'h00;
      {alm_claim, alm_lvl, gp_en, gp_lvl} = 8'h00;
      test_pass = 1'b1;
      seed = 32'h688AD0D7;
      period = seed[7:0];
      model_reg = 16'h0000;
      n_mismatch = 0;
      num_checks = 0;
      do_reset(1'b1);
      check(16'(test_act), 16'h0001);
      run_len(HP);
      rd_chk(7'h34);
      repeat (8) begin
         seed = lfsr_next(seed);
         wr_byte(7'h34, seed[7:0]);
         wr_byte(7'h35, seed[15:8]);
         wr_byte(7'h33, seed[23:16]);
         rd_chk(7'h34 + 7'(seed[25:24]));
         check(16'(rev), 16'(model_reg[9]));
      end
      wr_byte(7'h35, 8'h00);
      wait_test(1'b0);
      for (int k = 0; k < 4; k++) begin
         wr_byte(7'h34, 8'(4 + k));
         pulse(1'b1);
         check(16'({oe[k % 2], pin[k % 2]}), 16'(2 + k / 2));
         pulse(1'b0);
         check(16'(pin[k % 2]), 16'(1 - k / 2));
      end
      // Data-ready on pin 0, alarm and general claims on both pins contend
      wr_byte(7'h34, 8'h06);
      pulse(1'b1);
      @(posedge mclk);
      {alm_claim, alm_lvl, gp_en, gp_lvl} <= 8'hCF;
      repeat (3) @(negedge mclk);
      check(16'({oe, pin}), 16'h000D);
      wr_byte(7'h34, 8'h00);
      repeat (3) @(negedge mclk);
      check(16'({oe, pin}), 16'h000C);
      @(posedge mclk);
      alm_claim <= 2'b00;
      repeat (3) @(negedge mclk);
      check(16'({oe, pin}), 16'h000F);
      // Continuous self-test in low power, failing sensor
      @(posedge mclk);
      low_power <= 1'b1;
      test_pass <= 1'b0;
      wr_byte(7'h35, 8'h01);
      wait_test(1'b1);
      run_len(LP);
      wait_test(1'b1);
      wr_byte(7'h35, 8'h00);
      wait_test(1'b0);
      repeat (10) @(negedge mclk);
      check(16'(test_act), 16'h0000);
      // Reset in mid-run keeps the retained bits only
      wr_byte(7'h34, 8'hFF);
      wr_byte(7'h35, 8'hFF);
      wait_test(1'b1);
      do_reset(1'b0);
      check(16'(test_act), 16'h0000);
      rd_chk(7'h35);
      check(16'(rev), 16'h0001);
      check(16'(period_o), 16'(period));
      // First power clears everything and runs the boot test
      do_reset(1'b1);
      run_len(LP);
      rd_chk(7'h34);
      final_report();
   end
endmodule
`default_nettype wire
